/* common/half_key_pkg.sv */
// Package: key field layout, frame classes, range-checker and register map for the half-key builder
`default_nettype none
package half_key_pkg;
  // ----------------------------------------------------------------------------
  // Key field positions and widths
  // ----------------------------------------------------------------------------
  localparam int KEY_LO = 96;
  localparam int KEY_W = 85;
  localparam int POS_TYPE = 96;
  localparam int W_TYPE = 16;
  localparam int POS_IPSNAP = 112;
  localparam int POS_IPV4 = 113;
  localparam int POS_FRAG = 114;
  localparam int POS_LATER = 115;
  localparam int POS_OPTS = 116;
  localparam int POS_DSCP = 117;
  localparam int W_DSCP = 6;
  localparam int POS_ADDR = 123;
  localparam int W_ADDR = 32;
  localparam int POS_L4 = 155;
  localparam int POS_TCP = 156;
  localparam int POS_SPORT = 157;
  localparam int W_PORT = 16;
  localparam int POS_RNG = 173;
  localparam int NUM_RANGES = 8;

  // ----------------------------------------------------------------------------
  // Protocol constants
  // ----------------------------------------------------------------------------
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [15:0] OAM_TYPE_OR_PORT_FIELD = 16'h8902;
  localparam logic [7:0] OAM_HI = 8'h89;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [3:0] IPV4_MIN_HLEN = 4'h5;

  // Frame classes decided by the parser
  typedef enum logic [2:0] {
    FR_TYPE_OR_PORT_FIELD = 3'h0,
    FR_LLC = 3'h1,
    FR_SNAP = 3'h2,
    FR_IPV4 = 3'h3,
    FR_IPV6 = 3'h4,
    FR_ARP = 3'h5
  } frame_class_t;

  // Range checker types
  typedef enum logic [2:0] {
    RNG_SPORT = 3'h0,
    RNG_DPORT = 3'h1,
    RNG_EITHER = 3'h2,
    RNG_VID = 3'h3,
    RNG_DSCP = 3'h4
  } range_type_t;

  // Pipeline states (one-hot)
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OUT = 2'b10
  } pipe_state_t;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_DEST_SUB = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RANGE_BASE = 8'h20;
  localparam logic [7:0] DEST_SUB_RESET = 8'h00;
  localparam int RNG_TYPE_POS = 0;
  localparam int RNG_LO_POS = 0;
  localparam int RNG_HI_POS = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

/* verilog/half_key_builder.sv */
// Design: upper half-key builder for the first-stage classifier, with AHB-Lite configuration
// ----------------------------------------------------------------------------
// Functional notes
// - Type field at key bit 96, 16 bits; LLC gives destination and source SAP.
// - SNAP fills type field with protocol identifier bytes four and three.
// - IP L4_TRANSPORT_FLAG gives destination port; other IP gives protocol number.
// - ARP and EtherType frames copy EtherType into type field.
// - OAM 0x8902: upper byte 0x89, bit 7 masquerade, bits 6:0 level.
// - OAM encoding in type field sets the OAM frame flag.
// - Bit 112 set for IPv4, IPv6 or SNAP.
// - Bit 113 set only for IPv4.
// - Bit 114 set when IPv4 has more-fragments or nonzero offset.
// - Bit 115 set when IPv4 fragment offset is nonzero.
// - Bit 116 set when IPv4 header length exceeds five words.
// - Translated DSCP placed at bit 117, six bits.
// - Address field at bit 123, 32 bits; LLC gives control plus three payload bytes.
// - SNAP address field: identifier bytes two to zero then payload byte zero.
// - IP address field: low 32 bits of source address.
// - OAM, ARP, EtherType frames: first four payload bytes.
// - Per-port enable substitutes destination IP for source IP.
// - Bit 155 set for IP frames carrying TCP or UDP.
// - Bit 156 set only for IP frames carrying TCP.
// - L4_TRANSPORT_FLAG source port at bit 157, 16 bits.
// - Eight-bit range mask at bit 173, one bit per checker.
// - Checkers test source, destination, either port, VID or translated DSCP.
// - Type-encoded flag set when EtherType/length is at least 0x600.
// - OAM frame flag set for Y.1731 frames with EtherType 0x8902.
// ----------------------------------------------------------------------------
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module half_key_builder
  import half_key_pkg::*;
#(
  parameter int NUM_PORTS = 12,
  parameter int PORT_IDX_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Parsed frame from the parser
  input wire logic frameValid,
  input wire logic [2:0] frameClass,
  input wire logic [PORT_IDX_W-1:0] ingressPort,
  input wire logic [15:0] etherTypeLen,
  input wire logic [7:0] llcDsap,
  input wire logic [7:0] llcSsap,
  input wire logic [7:0] llcCtrl,
  input wire logic [39:0] snapPid,
  input wire logic [31:0] payloadHead,
  input wire logic oamMasquerade,
  input wire logic [6:0] oamLevel,
  input wire logic [7:0] ipProto,
  input wire logic [3:0] ipv4HeaderLen,
  input wire logic ipv4MoreFrags,
  input wire logic [12:0] ipv4FragOffset,
  input wire logic [31:0] srcIpLow,
  input wire logic [31:0] dstIpLow,
  input wire logic [15:0] l4SrcPort,
  input wire logic [15:0] l4DstPort,
  input wire logic frameTagged,
  input wire logic [11:0] frameVid,
  input wire logic [11:0] portDefaultVid,
  input wire logic [5:0] translatedDscp,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Key to the match stage
  output logic keyValid,
  output logic [KEY_W-1:0] normalHalfKey,
  output logic typeEncodedFlag,
  output logic oamFrameFlag
);

  // The substitution enables are read and written as one bus word
  if (PORT_IDX_W < 1 || NUM_PORTS > (1 << PORT_IDX_W) || NUM_PORTS > 32) begin : g_badPorts
    $error("half_key_builder: port count does not fit");
  end
  // Range registers are decoded from three address bits
  if (NUM_RANGES != 8) begin : g_badRanges
    $error("half_key_builder: range count must be eight");
  end

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  logic [NUM_PORTS-1:0] destSubEnable_q;
  logic [2:0] rngType_q [NUM_RANGES];
  logic [15:0] rngLo_q [NUM_RANGES];
  logic [15:0] rngHi_q [NUM_RANGES];
  logic [31:0] keyCount_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  pipe_state_t state_q;

  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic isCtrlWord(input logic [7:0] a);
    // Range registers take two words each: even = type, odd = low/high bounds
    isCtrlWord = (a >= REG_RANGE_BASE) && (a < REG_RANGE_BASE + 8'(NUM_RANGES * 8));
  endfunction

  // Range i sits at base + 8*i, so its index is the offset over eight
  function automatic logic [2:0] rangeIdx(input logic [7:0] a);
    logic [7:0] offs;
    offs = a - REG_RANGE_BASE;
    rangeIdx = offs[5:3];
  endfunction

  logic addrPhase;
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      destSubEnable_q <= NUM_PORTS'(DEST_SUB_RESET);
      for (int i = 0; i < NUM_RANGES; i++) begin
        rngType_q[i] <= RNG_SPORT;
        rngLo_q[i] <= 16'h0000;
        rngHi_q[i] <= 16'h0000;
      end
    end else if (wrPend_q) begin
      if (wrAddr_q == REG_DEST_SUB) begin
        destSubEnable_q <= hwdata[NUM_PORTS-1:0];
      end else if (isCtrlWord(wrAddr_q)) begin
        if (wrAddr_q[2] == 1'b0) begin
          rngType_q[rangeIdx(wrAddr_q)] <= hwdata[RNG_TYPE_POS +: 3];
        end else begin
          rngLo_q[rangeIdx(wrAddr_q)] <= hwdata[RNG_LO_POS +: 16];
          rngHi_q[rangeIdx(wrAddr_q)] <= hwdata[RNG_HI_POS +: 16];
        end
      end
    end
  end

  // Read data is prepared during the address phase, so zero wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      if (haddr == REG_DEST_SUB) begin
        hrdata <= 32'(destSubEnable_q);
      end else if (haddr == REG_STATUS) begin
        hrdata <= keyCount_q;
      end else if (isCtrlWord(haddr) && haddr[2]) begin
        hrdata <= {rngHi_q[rangeIdx(haddr)], rngLo_q[rangeIdx(haddr)]};
      end else if (isCtrlWord(haddr)) begin
        hrdata <= {29'h0, rngType_q[rangeIdx(haddr)]};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Key field assembly
  // ----------------------------------------------------------------------------
  logic isIp, isIpv4, isL4, isTcp, isEtype, isOam, isFrag, isLater, hasOpts, useDest;
  logic [W_TYPE-1:0] typeField;
  logic [W_ADDR-1:0] addrField;
  logic [15:0] effVid;
  logic [NUM_RANGES-1:0] rngHit;

  // Frame-class decode shared by every field except the DSCP field
  always_comb begin
    isIpv4 = frameClass == FR_IPV4;
    isIp = isIpv4 || frameClass == FR_IPV6;
    isL4 = isIp && (ipProto == PROTO_TCP || ipProto == PROTO_UDP);
    isTcp = isIp && ipProto == PROTO_TCP;
    // Unused class codes fall back to plain EtherType handling
    isEtype = !(frameClass inside {FR_LLC, FR_SNAP, FR_IPV4, FR_IPV6, FR_ARP});
    isOam = isEtype && etherTypeLen == OAM_TYPE_OR_PORT_FIELD;
    // Non-IPv4 frames never raise layer-3 flags
    isFrag = isIpv4 && (ipv4MoreFrags || ipv4FragOffset != 13'h0000);
    isLater = isIpv4 && ipv4FragOffset != 13'h0000;
    hasOpts = isIpv4 && ipv4HeaderLen > IPV4_MIN_HLEN;
    // An index past the last port never substitutes
    useDest = (32'(ingressPort) < 32'(NUM_PORTS)) && destSubEnable_q[ingressPort];
    effVid = {4'h0, frameTagged ? frameVid : portDefaultVid};
  end

  // Overloaded type field
  always_comb begin
    case (frameClass)
      FR_LLC: typeField = {llcDsap, llcSsap};
      FR_SNAP: typeField = snapPid[39:24];
      FR_IPV4, FR_IPV6: typeField = isL4 ? l4DstPort : {8'h00, ipProto};
      FR_ARP: typeField = etherTypeLen;
      default: begin
        // OAM overloads the type field; its flag tells rules apart
        typeField = isOam ? {OAM_HI, oamMasquerade, oamLevel} : etherTypeLen;
      end
    endcase
  end

  // Overloaded source-address field
  always_comb begin
    case (frameClass)
      FR_LLC: addrField = {llcCtrl, payloadHead[31:8]};
      FR_SNAP: addrField = {snapPid[23:0], payloadHead[31:24]};
      FR_IPV4, FR_IPV6: addrField = useDest ? dstIpLow : srcIpLow;
      default: addrField = payloadHead;
    endcase
  end

  // Range checkers: port types only ever match TCP or UDP frames
  always_comb begin
    for (int i = 0; i < NUM_RANGES; i++) begin
      case (rngType_q[i])
        RNG_SPORT: rngHit[i] = isL4 && inRange(l4SrcPort, rngLo_q[i], rngHi_q[i]);
        RNG_DPORT: rngHit[i] = isL4 && inRange(l4DstPort, rngLo_q[i], rngHi_q[i]);
        RNG_EITHER: rngHit[i] = isL4 && (inRange(l4SrcPort, rngLo_q[i], rngHi_q[i])
                                 || inRange(l4DstPort, rngLo_q[i], rngHi_q[i]));
        RNG_VID: rngHit[i] = inRange(effVid, rngLo_q[i], rngHi_q[i]);
        RNG_DSCP: rngHit[i] = inRange({10'h000, translatedDscp}, rngLo_q[i], rngHi_q[i]);
        // Reserved type codes disable the checker
        default: rngHit[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Output stage: one cycle from frameValid to keyValid
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      keyValid <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= frameValid ? ST_OUT : ST_IDLE;
        ST_OUT: state_q <= frameValid ? ST_OUT : ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
      keyValid <= frameValid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyCount_q <= 32'h0000_0000;
    end else if (state_q == ST_OUT) begin
      keyCount_q <= keyCount_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------------
  // Key registers, one per field group, held until the next frame
  // ----------------------------------------------------------------------------
  logic [W_TYPE-1:0] typeKey_q;
  logic [1:0] classKey_q;
  logic [2:0] l3Key_q;
  logic [W_DSCP-1:0] dscpKey_q;
  logic [W_ADDR-1:0] addrKey_q;
  logic [1:0] l4Key_q;
  logic [W_PORT-1:0] sportKey_q;
  logic [NUM_RANGES-1:0] rngKey_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      typeKey_q <= '0;
    end else if (frameValid) begin
      typeKey_q <= typeField;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      classKey_q <= 2'b00;
    end else if (frameValid) begin
      classKey_q <= {isIpv4, isIp || frameClass == FR_SNAP};
    end
  end

  // Fragment and options flags read as zero for anything but IPv4
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l3Key_q <= 3'b000;
    end else if (frameValid) begin
      l3Key_q <= {hasOpts, isLater, isFrag};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dscpKey_q <= '0;
    end else if (frameValid) begin
      dscpKey_q <= translatedDscp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addrKey_q <= '0;
    end else if (frameValid) begin
      addrKey_q <= addrField;
    end
  end

  // A stale port would look like a real one to a match rule
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l4Key_q <= 2'b00;
      sportKey_q <= '0;
    end else if (frameValid) begin
      l4Key_q <= {isTcp, isL4};
      sportKey_q <= isL4 ? l4SrcPort : 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rngKey_q <= '0;
    end else if (frameValid) begin
      rngKey_q <= rngHit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      typeEncodedFlag <= 1'b0;
      oamFrameFlag <= 1'b0;
    end else if (frameValid) begin
      typeEncodedFlag <= etherTypeLen >= TYPE_MIN;
      oamFrameFlag <= isOam;
    end
  end

  // Pure wiring: every key bit comes straight from a register
  always_comb begin
    normalHalfKey = '0;
    normalHalfKey[POS_TYPE-KEY_LO +: W_TYPE] = typeKey_q;
    normalHalfKey[POS_IPSNAP-KEY_LO] = classKey_q[0];
    normalHalfKey[POS_IPV4-KEY_LO] = classKey_q[1];
    normalHalfKey[POS_FRAG-KEY_LO] = l3Key_q[0];
    normalHalfKey[POS_LATER-KEY_LO] = l3Key_q[1];
    normalHalfKey[POS_OPTS-KEY_LO] = l3Key_q[2];
    normalHalfKey[POS_DSCP-KEY_LO +: W_DSCP] = dscpKey_q;
    normalHalfKey[POS_ADDR-KEY_LO +: W_ADDR] = addrKey_q;
    normalHalfKey[POS_L4-KEY_LO] = l4Key_q[0];
    normalHalfKey[POS_TCP-KEY_LO] = l4Key_q[1];
    normalHalfKey[POS_SPORT-KEY_LO +: W_PORT] = sportKey_q;
    normalHalfKey[POS_RNG-KEY_LO +: NUM_RANGES] = rngKey_q;
  end

endmodule // half_key_builder
`default_nettype wire

/* dv/half_key_monitor.sv */
// Checker: port-level properties of the half-key builder
`default_nettype none
module half_key_monitor
  import half_key_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame side
  input wire logic frameValid,
  input wire logic [2:0] frameClass,
  input wire logic [15:0] etherTypeLen,
  input wire logic [3:0] ipv4HeaderLen,
  input wire logic ipv4MoreFrags,
  input wire logic [12:0] ipv4FragOffset,
  input wire logic [5:0] translatedDscp,
  // Key side
  input wire logic keyValid,
  input wire logic [KEY_W-1:0] normalHalfKey,
  input wire logic typeEncodedFlag,
  input wire logic oamFrameFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_kv; frameValid |=> keyValid; endproperty
  a_kv: assert property (p_kv) else $error("key missing");
  property p_kvOff; !frameValid |=> !keyValid; endproperty
  a_kvOff: assert property (p_kvOff) else $error("stray key");
  property p_ipSnap; frameValid |=> normalHalfKey[16] == $past(frameClass inside {FR_SNAP, FR_IPV4, FR_IPV6}); endproperty
  a_ipSnap: assert property (p_ipSnap) else $error("ip or snap bit");
  property p_ipv4; frameValid |=> normalHalfKey[17] == $past(frameClass == FR_IPV4); endproperty
  a_ipv4: assert property (p_ipv4) else $error("ipv4 bit");
  property p_frag; frameValid && frameClass == FR_IPV4 |=> normalHalfKey[18] == $past(ipv4MoreFrags || ipv4FragOffset != 13'h0000); endproperty
  a_frag: assert property (p_frag) else $error("fragment bit");
  property p_later; frameValid && frameClass == FR_IPV4 |=> normalHalfKey[19] == $past(ipv4FragOffset != 13'h0000); endproperty
  a_later: assert property (p_later) else $error("later fragment bit");
  property p_opts; frameValid && frameClass == FR_IPV4 |=> normalHalfKey[20] == $past(ipv4HeaderLen > IPV4_MIN_HLEN); endproperty
  a_opts: assert property (p_opts) else $error("options bit");
  property p_noL3; frameValid && frameClass != FR_IPV4 |=> normalHalfKey[20:18] == 3'h0; endproperty
  a_noL3: assert property (p_noL3) else $error("stale layer-3 bits");
  property p_dscp; frameValid |=> normalHalfKey[26:21] == $past(translatedDscp); endproperty
  a_dscp: assert property (p_dscp) else $error("dscp field");
  property p_tenc; frameValid |=> typeEncodedFlag == $past(etherTypeLen >= TYPE_MIN); endproperty
  a_tenc: assert property (p_tenc) else $error("type encoded flag");
  property p_oam; frameValid |=> oamFrameFlag == $past(etherTypeLen == OAM_TYPE_OR_PORT_FIELD
    && !(frameClass inside {FR_LLC, FR_SNAP, FR_IPV4, FR_IPV6, FR_ARP})); endproperty
  a_oam: assert property (p_oam) else $error("oam frame flag");
endmodule // half_key_monitor
`default_nettype wire

/* dv/match_stage_model.sv */
// Partner: match stage that captures each key handed on
`default_nettype none
module match_stage_model
  import half_key_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Key in
  input wire logic keyValid,
  input wire logic [KEY_W-1:0] normalHalfKey,
  // Captured view
  output logic [KEY_W-1:0] lastKey,
  output logic [31:0] keyCount
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastKey <= '0;
      keyCount <= 32'h0;
    end else if (keyValid) begin
      lastKey <= normalHalfKey;
      keyCount <= keyCount + 32'h1;
    end
  end
endmodule // match_stage_model
`default_nettype wire

/* dv/tb_top.sv */
// Testbench: frame classes and AHB-Lite configuration of the half-key builder
`default_nettype none
module tb_top
  import half_key_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, frameValid = 1'b0, oamMasquerade = 1'b1, ipv4MoreFrags = 1'b1;
  logic frameTagged = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, keyValid, typeEncodedFlag, oamFrameFlag;
  logic [2:0] frameClass = FR_LLC;
  logic [3:0] ingressPort = 4'h0, ipv4HeaderLen = 4'h6;
  logic [7:0] llcDsap = 8'haa, llcSsap = 8'h55, llcCtrl = 8'h03, ipProto = 8'h06, haddr = 8'h00;
  logic [39:0] snapPid = 40'h0102030405;
  logic [31:0] payloadHead = 32'h11223344, srcIpLow = 32'hc0a80001, dstIpLow = 32'h0a000001;
  logic [31:0] hwdata = 32'h0, hrdata, rdata, keyCount;
  logic [6:0] oamLevel = 7'h05;
  logic [12:0] ipv4FragOffset = 13'h0003;
  logic [15:0] etherTypeLen = 16'h0040, l4SrcPort = 16'h0096, l4DstPort = 16'h01bb;
  logic [11:0] frameVid = 12'h00c, portDefaultVid = 12'h00f;
  logic [5:0] translatedDscp = 6'h00;
  logic [1:0] htrans = 2'b00;
  logic [KEY_W-1:0] normalHalfKey, lastKey;
  logic [31:0] rngCfg [10] = '{32'h0, 32'h00c80064, 32'h3, 32'h0014000a, 32'h4, 32'h00080008,
    32'h1, 32'h01bb01bb, 32'h2, 32'h00500050};
  int miscompares = 0, checkCount = 0, cycles = 0;

  half_key_builder u_half_key_builder (.clk, .rst_n, .frameValid, .frameClass, .ingressPort, .etherTypeLen,
    .llcDsap, .llcSsap, .llcCtrl, .snapPid, .payloadHead, .oamMasquerade, .oamLevel, .ipProto, .ipv4HeaderLen,
    .ipv4MoreFrags, .ipv4FragOffset, .srcIpLow, .dstIpLow, .l4SrcPort, .l4DstPort, .frameTagged, .frameVid,
    .portDefaultVid, .translatedDscp, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .keyValid, .normalHalfKey, .typeEncodedFlag, .oamFrameFlag);
  match_stage_model u_match_stage_model (.clk, .rst_n, .keyValid, .normalHalfKey, .lastKey, .keyCount);

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic completeRun;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      completeRun;
    end
  end

  task automatic check(input string what, input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic busXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= addr;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask

  task automatic rdReg(input logic [7:0] addr, input logic [31:0] exp);
    busXfer(1'b0, addr, 32'h0);
    check("hrdata", KEY_W'(rdata), KEY_W'(exp));
    check("hresp", KEY_W'(hresp), KEY_W'(1'b0));
    check("hreadyout", KEY_W'(hreadyout), KEY_W'(1'b1));
  endtask

  // Fields are set at an edge just before; the frame pulse goes out with them
  task automatic sendFrame(input string name, input logic [KEY_W-1:0] k, input logic oam, input logic te);
    frameValid <= 1'b1;
    @(posedge clk);
    frameValid <= 1'b0;
    #1;
    check("keyValid", KEY_W'(keyValid), KEY_W'(1'b1));
    check("key", normalHalfKey, k);
    check("oamFrameFlag", KEY_W'(oamFrameFlag), KEY_W'(oam));
    check("typeEncodedFlag", KEY_W'(typeEncodedFlag), KEY_W'(te));
    @(posedge clk);
    #1;
    check("lastKey", lastKey, k);
    $display("test %s done", name);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdReg(REG_DEST_SUB, 32'h0);
    busXfer(1'b1, 8'h10, 32'hffffffff);
    rdReg(8'h10, 32'h0);
    for (int i = 0; i < 10; i++) busXfer(1'b1, REG_RANGE_BASE + 8'(4 * i), rngCfg[i]);
    rdReg(8'h24, 32'h00c80064);
    $display("test registers done");
    @(posedge clk);
    sendFrame("llc", {8'h02, 16'h0, 2'b00, 32'h03112233, 6'h00, 5'b00000, 16'haa55}, 1'b0, 1'b0);
    @(posedge clk);
    frameClass <= FR_SNAP;
    frameTagged <= 1'b1;
    sendFrame("snap", {8'h02, 16'h0, 2'b00, 32'h03040511, 6'h00, 5'b00001, 16'h0102}, 1'b0, 1'b0);
    @(posedge clk);
    frameClass <= FR_IPV4;
    etherTypeLen <= 16'h0800;
    frameVid <= 12'h032;
    translatedDscp <= 6'h08;
    sendFrame("ipv4 tcp", {8'h0d, 16'h0096, 2'b11, 32'hc0a80001, 6'h08, 5'b11111, 16'h01bb}, 1'b0, 1'b1);
    busXfer(1'b1, REG_DEST_SUB, 32'h4);
    @(posedge clk);
    ingressPort <= 4'h2;
    frameClass <= FR_IPV6;
    ipProto <= PROTO_UDP;
    l4SrcPort <= 16'h0050;
    l4DstPort <= 16'h0050;
    sendFrame("ipv6 udp", {8'h14, 16'h0050, 2'b01, 32'h0a000001, 6'h08, 5'b00001, 16'h0050}, 1'b0, 1'b1);
    @(posedge clk);
    frameClass <= FR_IPV4;
    ipProto <= 8'h01;
    ipv4HeaderLen <= IPV4_MIN_HLEN;
    ipv4FragOffset <= 13'h0000;
    sendFrame("ipv4 other", {8'h04, 16'h0, 2'b00, 32'h0a000001, 6'h08, 5'b00111, 16'h0001}, 1'b0, 1'b1);
    @(posedge clk);
    frameClass <= FR_TYPE_OR_PORT_FIELD;
    etherTypeLen <= OAM_TYPE_OR_PORT_FIELD;
    sendFrame("oam", {8'h04, 16'h0, 2'b00, 32'h11223344, 6'h08, 5'b00000, 16'h8985}, 1'b1, 1'b1);
    @(posedge clk);
    frameClass <= FR_ARP;
    etherTypeLen <= 16'h0806;
    sendFrame("arp", {8'h04, 16'h0, 2'b00, 32'h11223344, 6'h08, 5'b00000, 16'h0806}, 1'b0, 1'b1);
    busXfer(1'b1, 8'h48, 32'h7);
    busXfer(1'b1, 8'h4c, 32'hffff0000);
    busXfer(1'b1, 8'h50, 32'h3);
    busXfer(1'b1, 8'h54, 32'hffff0000);
    rdReg(8'h48, 32'h7);
    @(posedge clk);
    frameClass <= FR_TYPE_OR_PORT_FIELD;
    etherTypeLen <= 16'h88cc;
    sendFrame("type_or_port_field", {8'h44, 16'h0, 2'b00, 32'h11223344, 6'h08, 5'b00000, 16'h88cc}, 1'b0, 1'b1);
    rdReg(REG_STATUS, 32'h8);
    check("keyCount", KEY_W'(keyCount), KEY_W'(32'h8));
    completeRun;
  end
endmodule // tb_top

bind half_key_builder half_key_monitor u_half_key_monitor (.clk, .rst_n, .frameValid, .frameClass, .etherTypeLen,
  .ipv4HeaderLen, .ipv4MoreFrags, .ipv4FragOffset, .translatedDscp, .keyValid, .normalHalfKey, .typeEncodedFlag,
  .oamFrameFlag);
`default_nettype wire
